//--- tss_pkg.sv
// constants, types and state layout of the touch scan sequencer
//
// Behaviour
// - every scan period runs sensing, then processing, then a waiting timer phase
// - sensing visits enabled inputs only, lowest index first; disabled ones are skipped
// - processing evaluates the sensor data, then refreshes pin states and host status
// - output pins, touch status and interrupt raise change only in processing, once per period
// - scan period is host set, never shorter than 15 ms, reaching beyond one second
// - a detected touch raises the interrupt within one scan period
// - active mode scans every enabled sensor each short period, 30 ms by default
// - doze mode uses a longer period, 195 ms by default
// - sleep mode scans nothing; only host port and pin inputs stay alive
// - active and doze periods are two separate host settings
// - inactivity timer moves active to doze; a zero limit disables it
// - by default any button touch in doze returns to active
// - with wake sequence enabled, doze leaves only after the touch sequence completes
// - host may force the mode through the mode control register
// - sensor turns on when ticks reach threshold plus hysteresis
// - sensor turns off only when ticks fall below threshold minus hysteresis, or when its input is disabled
// - wheel reports one on state when any of its sensors is on
// - wheel position by centre of gravity, zero up to the configured maximum
// - position zero at the lowest wheel input, maximum at the highest
// - rotation flagged when position moves by the step; clockwise when increasing
// - per sensor sensitivity sets the number of accumulate and transfer cycles
// - each cycle accumulates, compensates and transfers; then the ticks are stored
// - interrupt tells the host that new sensor status is ready to read
package tss_pkg;

	// ----------------------------------------------------------------
	// sizes and timing
	// ----------------------------------------------------------------
	localparam int NSENS = 12;
	localparam int TW = 16;
	localparam int CLK_FREQ_HZ = 125000000;
	localparam int MS_PER_S = 1000;
	localparam int CYC_PER_MS_DEF = CLK_FREQ_HZ / MS_PER_S;
	localparam logic [10:0] PER_MIN_MS = 11'd15;
	localparam logic [10:0] ACT_PER_MS_RST = 11'd30;
	localparam logic [10:0] DOZE_PER_MS_RST = 11'd195;
	localparam logic [5:0] SYNC_WAIT = 6'h3;
	localparam logic [5:0] REP_BASE = 6'h4;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_MODE = 8'h00;
	localparam logic [7:0] REG_ENABLE = 8'h04;
	localparam logic [7:0] REG_WHEEL_CFG = 8'h08;
	localparam logic [7:0] REG_ACT_PER = 8'h0C;
	localparam logic [7:0] REG_DOZE_PER = 8'h10;
	localparam logic [7:0] REG_IDLE_LIM = 8'h14;
	localparam logic [7:0] REG_THRESH = 8'h18;
	localparam logic [7:0] REG_SENS = 8'h1C;
	localparam logic [7:0] REG_WAKE = 8'h20;
	localparam logic [7:0] REG_STATUS = 8'h24;
	localparam logic [7:0] REG_WHEEL_POS = 8'h28;
	localparam logic [7:0] REG_GPIO = 8'h2C;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int WMAX_LSB = 16;
	localparam int HYST_LSB = 16;
	localparam int STEP_LSB = 24;
	localparam int WAKE_A_LSB = 4;
	localparam int WAKE_B_LSB = 8;
	localparam int GPI_LSB = 8;
	localparam logic [11:0] EN_RST = 12'hFFF;
	localparam logic [11:0] WMASK_RST = 12'hFC0;
	localparam logic [7:0] WMAX_RST = 8'hFF;
	localparam logic [15:0] IDLE_LIM_RST = 16'h07D0;
	localparam logic [15:0] THR_RST = 16'h0064;
	localparam logic [7:0] HYST_RST = 8'h0A;
	localparam logic [7:0] STEP_RST = 8'h04;
	localparam logic [23:0] SENS_RST = 24'h555555;

	// ----------------------------------------------------------------
	// modes, phases and types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_ACTIVE = 2'h0,
		MODE_DOZE = 2'h1,
		MODE_SLEEP = 2'h2
	} tss_mode_t;

	typedef enum logic [5:0] {
		ST_TIMER = 6'h01,
		ST_SENSE = 6'h02,
		ST_PACC = 6'h04,
		ST_PDIV = 6'h08,
		ST_PUPD = 6'h10,
		ST_SLEEP = 6'h20
	} tss_phase_t;

	typedef enum logic [3:0] {
		STEP_ACC = 4'h1,
		STEP_COMP = 4'h2,
		STEP_XFER = 4'h4,
		STEP_STORE = 4'h8
	} tss_step_t;

	// strobes toward the analog front end
	typedef struct packed {
		logic [3:0] sel;
		logic acc;
		logic comp;
		logic xfer;
		logic store;
	} tss_afe_t;

	typedef struct packed {
		tss_phase_t phase;
		tss_step_t step;
		tss_mode_t mode;
		logic [5:0] rep;
		logic [3:0] idx;
		logic [16:0] pre;
		logic [10:0] per_ms;
		logic [15:0] idle_ms;
		logic [11:0] en;
		logic [11:0] wmask;
		logic [7:0] wmax;
		logic [10:0] act_per;
		logic [10:0] doze_per;
		logic [15:0] idle_lim;
		logic [15:0] thr;
		logic [7:0] hyst;
		logic [7:0] rstep;
		logic [23:0] sens;
		logic wk_en;
		logic [3:0] wk_a;
		logic [3:0] wk_b;
		logic [1:0] wk_st;
		logic [NSENS-1:0][TW-1:0] ticks;
		logic [11:0] btn_w;
		logic [11:0] btn;
		logic wheel_on;
		logic cw;
		logic ccw;
		logic [7:0] pos;
		logic [39:0] num;
		logic [39:0] den;
		logic [3:0] wcnt;
		logic [2:0] dbit;
		logic [7:0] quo;
		logic [7:0] gpo_sh;
		logic [7:0] gpo;
		logic [7:0] gpi_s1;
		logic [7:0] gpi_s2;
		logic [7:0] general_input_function;
		logic [TW-1:0] tk_s1;
		logic [TW-1:0] tk_s2;
		logic irq;
		logic [31:0] rdata;
		logic rerr;
		tss_afe_t afe;
	} tss_state_t;

endpackage

//--- tss_scan_seq.sv
// scan sequencer, touch decision, wheel and mode control with an apb register port
//
// Implementation choices: the register addresses and the APB interface to the registers.
module tss_scan_seq #(
	parameter int CYC_PER_MS = tss_pkg::CYC_PER_MS_DEF // clock cycles per millisecond
) (
	input wire logic sys_clk_i, // 125 MHz system clock
	input wire logic resetn_i, // async reset, active low
	input wire logic ce_i, // clock enable, freezes all state when low
	input wire logic psel_i, // apb select
	input wire logic penable_i, // apb access phase
	input wire logic pwrite_i, // apb direction, high for write
	input wire logic [7:0] paddr_i, // apb byte address
	input wire logic [31:0] pwdata_i, // apb write data
	output logic [31:0] prdata_o, // apb read data
	output logic pready_o, // apb ready
	output logic pslverr_o, // apb error on unmapped address
	input wire logic [tss_pkg::TW-1:0] afe_ticks_i, // ticks from the front end converter
	output tss_pkg::tss_afe_t afe_o, // front end channel select and step strobes
	input wire logic [7:0] gpi_i, // general input pins
	output logic [7:0] gpio_o, // general output pins
	output logic [1:0] power_mode_o, // current operating mode
	output logic host_irq_n_o // interrupt to host, active low
);
	import tss_pkg::*;

	// ----------------------------------------------------------------
	// state and reset value
	// ----------------------------------------------------------------
	localparam tss_state_t ST_RST = '{
		phase: ST_TIMER,
		step: STEP_ACC,
		mode: MODE_ACTIVE,
		en: EN_RST,
		wmask: WMASK_RST,
		wmax: WMAX_RST,
		act_per: ACT_PER_MS_RST,
		doze_per: DOZE_PER_MS_RST,
		idle_lim: IDLE_LIM_RST,
		thr: THR_RST,
		hyst: HYST_RST,
		rstep: STEP_RST,
		sens: SENS_RST,
		default: '0
	};

	tss_state_t st;
	tss_state_t next_st;

	logic setup;
	logic wr;
	logic rd_acc;
	logic tick_ms;
	logic [10:0] per_sel;
	logic [10:0] period;
	logic [5:0] reps;
	logic [TW-1:0] cur_tk;
	logic [TW:0] on_lvl;
	logic rel_hit;
	logic [39:0] num_sum;
	logic [39:0] den_sum;
	logic [3:0] wcnt_n;
	logic [39:0] den_sh;
	logic [11:0] wheel_btn;
	logic new_wheel;
	logic [7:0] new_pos;
	logic [8:0] pos_up;
	logic [8:0] pos_dn;
	logic new_cw;
	logic new_ccw;
	logic [1:0] wdata_mode;

	// ----------------------------------------------------------------
	// helper terms
	// ----------------------------------------------------------------
	assign setup = psel_i & ~penable_i;
	assign wr = psel_i & penable_i & pwrite_i & ce_i;
	assign rd_acc = psel_i & penable_i & ~pwrite_i & ce_i;
	assign tick_ms = st.pre == 17'(CYC_PER_MS - 1);
	// per mode period, clamped so no period is shorter than the floor
	assign per_sel = (st.mode == MODE_DOZE) ? st.doze_per : st.act_per;
	assign period = (per_sel < PER_MIN_MS) ? PER_MIN_MS : per_sel;
	assign reps = REP_BASE << st.sens[2*st.idx +: 2];
	assign cur_tk = st.ticks[st.idx];
	assign on_lvl = {1'b0, st.thr} + {9'h000, st.hyst};
	// a threshold below the hysteresis has no reachable release level
	assign rel_hit = (st.thr > {8'h00, st.hyst}) && (cur_tk < st.thr - {8'h00, st.hyst});
	assign wcnt_n = st.wcnt + 4'h1;
	assign num_sum = st.num + 40'(32'(st.wcnt) * 32'(cur_tk));
	assign den_sum = st.den + {24'h000000, cur_tk};
	assign den_sh = st.den << st.dbit;
	assign wheel_btn = st.btn_w & st.en & st.wmask;
	assign new_wheel = |wheel_btn;
	assign new_pos = (st.den == 40'h0) ? st.pos : st.quo;
	assign pos_up = {1'b0, st.pos} + {1'b0, st.rstep};
	assign pos_dn = {1'b0, new_pos} + {1'b0, st.rstep};
	assign new_cw = new_wheel && st.wheel_on && ({1'b0, new_pos} >= pos_up);
	assign new_ccw = new_wheel && st.wheel_on && ({1'b0, st.pos} >= pos_dn);
	assign wdata_mode = pwdata_i[1:0];

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		if (ce_i) begin
			// pin inputs cross into the clock domain through two flops
			next_st.gpi_s1 = gpi_i;
			next_st.gpi_s2 = st.gpi_s1;
			next_st.tk_s1 = afe_ticks_i;
			next_st.tk_s2 = st.tk_s1;
			next_st.afe = '0;
			next_st.afe.sel = st.idx;

			// apb read data is taken in the setup cycle so it leaves a flop
			if (setup) begin
				next_st.rerr = 1'b0;
				case (paddr_i)
					REG_MODE: next_st.rdata = {30'h0, st.mode};
					REG_ENABLE: next_st.rdata = {20'h0, st.en};
					REG_WHEEL_CFG: next_st.rdata = {8'h0, st.wmax, 4'h0, st.wmask};
					REG_ACT_PER: next_st.rdata = {21'h0, st.act_per};
					REG_DOZE_PER: next_st.rdata = {21'h0, st.doze_per};
					REG_IDLE_LIM: next_st.rdata = {16'h0, st.idle_lim};
					REG_THRESH: next_st.rdata = {st.rstep, st.hyst, st.thr};
					REG_SENS: next_st.rdata = {8'h0, st.sens};
					REG_WAKE: next_st.rdata = {20'h0, st.wk_b, st.wk_a, 3'h0, st.wk_en};
					REG_STATUS: next_st.rdata = {16'h0, st.irq, st.ccw, st.cw, st.wheel_on, st.btn};
					REG_WHEEL_POS: next_st.rdata = {24'h0, st.pos};
					REG_GPIO: next_st.rdata = {16'h0, st.general_input_function, st.gpo_sh};
					default: begin
						next_st.rdata = 32'h0;
						next_st.rerr = 1'b1;
					end
				endcase
			end

			// configuration writes; output pins take the shadow later
			if (wr) begin
				case (paddr_i)
					REG_ENABLE: next_st.en = pwdata_i[11:0];
					REG_WHEEL_CFG: begin
						next_st.wmask = pwdata_i[11:0];
						next_st.wmax = pwdata_i[WMAX_LSB +: 8];
					end
					REG_ACT_PER: next_st.act_per = pwdata_i[10:0];
					REG_DOZE_PER: next_st.doze_per = pwdata_i[10:0];
					REG_IDLE_LIM: next_st.idle_lim = pwdata_i[15:0];
					REG_THRESH: begin
						next_st.thr = pwdata_i[15:0];
						next_st.hyst = pwdata_i[HYST_LSB +: 8];
						next_st.rstep = pwdata_i[STEP_LSB +: 8];
					end
					REG_SENS: next_st.sens = pwdata_i[23:0];
					REG_WAKE: begin
						next_st.wk_en = pwdata_i[0];
						next_st.wk_a = pwdata_i[WAKE_A_LSB +: 4];
						next_st.wk_b = pwdata_i[WAKE_B_LSB +: 4];
						next_st.wk_st = 2'h0;
					end
					REG_GPIO: next_st.gpo_sh = pwdata_i[7:0];
					default: ;
				endcase
			end

			// host read of status acknowledges the interrupt
			if (rd_acc && paddr_i == REG_STATUS) begin
				next_st.irq = 1'b0;
			end

			// millisecond base and period time, frozen in sleep
			if (st.phase != ST_SLEEP) begin
				next_st.pre = tick_ms ? 17'h0 : st.pre + 17'h1;
				if (tick_ms && st.per_ms != 11'h7FF) begin
					next_st.per_ms = st.per_ms + 11'h1;
				end
				if (tick_ms && st.mode == MODE_ACTIVE && st.idle_ms != 16'hFFFF) begin
					next_st.idle_ms = st.idle_ms + 16'h1;
				end
			end

			unique case (st.phase)
				// low power wait until the period has run out
				ST_TIMER: begin
					if (st.per_ms >= period) begin
						next_st.per_ms = 11'h0;
						next_st.pre = 17'h0;
						next_st.idx = 4'h0;
						next_st.rep = 6'h0;
						next_st.step = STEP_ACC;
						next_st.phase = ST_SENSE;
					end
				end
				// charge sequencing over the enabled inputs
				ST_SENSE: begin
					if (!st.en[st.idx] || (st.step == STEP_STORE && st.rep == SYNC_WAIT)) begin
						if (st.en[st.idx]) begin
							next_st.ticks[st.idx] = st.tk_s2;
						end
						next_st.rep = 6'h0;
						next_st.step = STEP_ACC;
						if (st.idx == 4'(NSENS - 1)) begin
							next_st.idx = 4'h0;
							next_st.num = 40'h0;
							next_st.den = 40'h0;
							next_st.wcnt = 4'h0;
							next_st.phase = ST_PACC;
						end else begin
							next_st.idx = st.idx + 4'h1;
						end
					end else begin
						unique case (st.step)
							STEP_ACC: begin
								next_st.afe.acc = 1'b1;
								next_st.step = STEP_COMP;
							end
							STEP_COMP: begin
								next_st.afe.comp = 1'b1;
								next_st.step = STEP_XFER;
							end
							STEP_XFER: begin
								next_st.afe.xfer = 1'b1;
								if (st.rep == reps - 6'h1) begin
									next_st.rep = 6'h0;
									next_st.step = STEP_STORE;
									next_st.afe.store = 1'b1;
								end else begin
									next_st.rep = st.rep + 6'h1;
									next_st.step = STEP_ACC;
								end
							end
							STEP_STORE: begin
								next_st.rep = st.rep + 6'h1;
							end
						endcase
					end
				end
				// touch decision and wheel sums, one sensor a cycle
				ST_PACC: begin
					if (!st.en[st.idx]) begin
						next_st.btn_w[st.idx] = 1'b0;
					end else if (!st.btn_w[st.idx] && {1'b0, cur_tk} >= on_lvl) begin
						next_st.btn_w[st.idx] = 1'b1;
					end else if (st.btn_w[st.idx] && rel_hit) begin
						next_st.btn_w[st.idx] = 1'b0;
					end
					if (st.en[st.idx] && st.wmask[st.idx]) begin
						next_st.num = num_sum;
						next_st.den = den_sum;
						next_st.wcnt = wcnt_n;
					end
					if (st.idx == 4'(NSENS - 1)) begin
						// scale so the quotient spans zero to the maximum
						if (st.en[st.idx] && st.wmask[st.idx]) begin
							next_st.num = 40'(num_sum * {32'h0, st.wmax});
							next_st.den = (wcnt_n < 4'h2) ? 40'h0 : 40'(den_sum * {36'h0, wcnt_n - 4'h1});
						end else begin
							next_st.num = 40'(st.num * {32'h0, st.wmax});
							next_st.den = (st.wcnt < 4'h2) ? 40'h0 : 40'(st.den * {36'h0, st.wcnt - 4'h1});
						end
						next_st.idx = 4'h0;
						next_st.dbit = 3'h7;
						next_st.quo = 8'h00;
						next_st.phase = ST_PDIV;
					end else begin
						next_st.idx = st.idx + 4'h1;
					end
				end
				// restoring divide, one quotient bit a cycle
				ST_PDIV: begin
					if (st.den != 40'h0 && st.num >= den_sh) begin
						next_st.num = st.num - den_sh;
						next_st.quo[st.dbit] = 1'b1;
					end
					if (st.dbit == 3'h0) begin
						next_st.phase = ST_PUPD;
					end else begin
						next_st.dbit = st.dbit - 3'h1;
					end
				end
				// the one cycle in which output pins, touch status and interrupt raise change
				ST_PUPD: begin
					next_st.btn = st.btn_w;
					next_st.wheel_on = new_wheel;
					next_st.cw = new_cw;
					next_st.ccw = new_ccw;
					if (new_wheel) begin
						next_st.pos = new_pos;
					end
					next_st.gpo = st.gpo_sh;
					next_st.general_input_function = st.gpi_s2;
					if (st.btn_w != st.btn || new_wheel != st.wheel_on || new_cw || new_ccw
							|| (new_wheel && new_pos != st.pos) || st.gpi_s2 != st.general_input_function) begin
						next_st.irq = 1'b1;
					end
					if (st.mode == MODE_ACTIVE) begin
						if (|(st.btn_w & st.en)) begin
							next_st.idle_ms = 16'h0;
						end else if (st.idle_lim != 16'h0 && st.idle_ms >= st.idle_lim) begin
							next_st.mode = MODE_DOZE;
							next_st.wk_st = 2'h0;
						end
					end else if (!st.wk_en) begin
						if (|(st.btn_w & st.en & ~st.wmask)) begin
							next_st.mode = MODE_ACTIVE;
							next_st.idle_ms = 16'h0;
						end
					end else begin
						// touch a, release a, touch b, release b
						unique case (st.wk_st)
							2'h0: if (st.btn_w[st.wk_a]) next_st.wk_st = 2'h1;
							2'h1: if (!st.btn_w[st.wk_a]) next_st.wk_st = 2'h2;
							2'h2: begin
								if (st.btn_w[st.wk_b]) begin
									next_st.wk_st = 2'h3;
								end else if (|(st.btn_w & st.en & ~st.wmask)) begin
									next_st.wk_st = 2'h0;
								end
							end
							2'h3: begin
								if (!st.btn_w[st.wk_b]) begin
									next_st.wk_st = 2'h0;
									next_st.mode = MODE_ACTIVE;
									next_st.idle_ms = 16'h0;
								end
							end
						endcase
					end
					next_st.phase = ST_TIMER;
				end
				// nothing scans; the general inputs still follow the pins
				ST_SLEEP: begin
					next_st.general_input_function = st.gpi_s2;
				end
			endcase

			// host forced mode takes priority over the automatic moves
			if (wr && paddr_i == REG_MODE && wdata_mode != 2'h3) begin
				next_st.mode = tss_mode_t'(wdata_mode);
				next_st.idle_ms = 16'h0;
				next_st.wk_st = 2'h0;
				if (wdata_mode == MODE_SLEEP) begin
					next_st.phase = ST_SLEEP;
					next_st.afe = '0;
				end else if (st.phase == ST_SLEEP) begin
					next_st.phase = ST_TIMER;
					next_st.per_ms = 11'h0;
					next_st.pre = 17'h0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st <= ST_RST;
		end else begin
			st <= next_st;
		end
	end

	// outputs; apb answers in its first access cycle
	assign prdata_o = st.rdata;
	assign pslverr_o = psel_i & penable_i & st.rerr;
	assign pready_o = psel_i & penable_i & ce_i;
	assign afe_o = st.afe;
	assign gpio_o = st.gpo;
	assign power_mode_o = st.mode;
	assign host_irq_n_o = ~st.irq;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	phase_onehot_a: assert property ($onehot(st.phase))
		else $error("scan phase not one-hot");
	sense_skip_a: assert property ((ce_i && st.phase == ST_SENSE && !st.en[st.idx]
			&& st.idx != 4'(NSENS - 1)) |=> st.idx == $past(st.idx) + 4'h1)
		else $error("disabled input not skipped in order");
	gpio_change_a: assert property ($changed(gpio_o) |-> $past(st.phase) == ST_PUPD)
		else $error("output pins changed outside processing");
	irq_raise_a: assert property ($fell(host_irq_n_o) |-> $past(st.phase) == ST_PUPD)
		else $error("interrupt raised outside processing");
	period_floor_a: assert property ((st.phase == ST_SENSE && $past(st.phase) == ST_TIMER)
			|-> $past(st.per_ms) >= PER_MIN_MS)
		else $error("scan period shorter than floor");
	sleep_quiet_a: assert property ((st.mode == MODE_SLEEP) |->
			(st.phase == ST_SLEEP && !afe_o.acc && !afe_o.xfer))
		else $error("scanning while asleep");
	touch_on_a: assert property ((ce_i && st.phase == ST_PACC && st.en[st.idx]
			&& {1'b0, cur_tk} >= on_lvl) |=> st.btn_w[$past(st.idx)])
		else $error("sensor did not turn on at touch level");
	band_hold_a: assert property ((ce_i && st.phase == ST_PACC && st.en[st.idx]
			&& st.btn_w[st.idx] && !rel_hit) |=> st.btn_w[$past(st.idx)])
		else $error("sensor released inside hysteresis band");
	release_off_a: assert property ((ce_i && st.phase == ST_PACC && st.btn_w[st.idx]
			&& rel_hit) |=> !st.btn_w[$past(st.idx)])
		else $error("sensor did not release below level");
	wheel_state_a: assert property ((ce_i && st.phase == ST_PUPD) |=>
			st.wheel_on == |(st.btn & st.en & st.wmask))
		else $error("wheel state disagrees with its sensors");
	first_rot_a: assert property ($rose(st.wheel_on) |-> (!st.cw && !st.ccw))
		else $error("rotation flagged on first touch scan");
	pos_range_a: assert property (st.wheel_on |-> st.pos <= st.wmax)
		else $error("wheel position beyond maximum");
	mode_force_a: assert property ((wr && paddr_i == REG_MODE && wdata_mode != 2'h3)
			|=> st.mode == $past(wdata_mode))
		else $error("forced mode not adopted");

endmodule

//--- tss_afe_model.sv
// front end stand-in that answers one tick word per selected input
module tss_afe_model (
	input wire logic clk_i, // system clock
	input wire tss_pkg::tss_afe_t afe_i, // select and strobes from the sequencer
	input wire logic [tss_pkg::NSENS-1:0][tss_pkg::TW-1:0] tk_i, // tick word per input
	output logic [tss_pkg::TW-1:0] ticks_o // converter result
);
	import tss_pkg::*;
	logic [2:0] hold = 3'h0;
	// result valid from store for a short window only; outside it the line shows the
	// inverse, so a late or early sample cannot match by luck
	always @(posedge clk_i) begin
		hold <= afe_i.store ? 3'h7 : (hold != 3'h0 ? hold - 3'h1 : 3'h0);
	end
	assign ticks_o = (afe_i.store || hold != 3'h0) ? tk_i[afe_i.sel] : ~tk_i[afe_i.sel];
endmodule

//--- touch_scan_sequencer_bench.sv
// self-checking bench of the touch scan sequencer
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module touch_scan_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import tss_pkg::*;
	logic sys_clk_i, resetn_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic pready, pslverr, irq_n, er;
	logic [7:0] paddr = 8'h00, general_input_function = 8'h00, gpo;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [1:0] pmode;
	logic [TW-1:0] ticks;
	tss_afe_t afe;
	logic [NSENS-1:0][TW-1:0] tk = '0;
	logic [11:0] en = EN_RST, exp_on = 12'h000, old_on;
	logic [3:0] last = 4'hB;
	int bad_count = 0, num_checks = 0, cyc = 0, stores = 0, pos, prv;
	logic [15:0] lv [6] = '{16'h0000, 16'h0059, 16'h005A, 16'h006D, 16'h006E, 16'h012C};

	tss_scan_seq #(.CYC_PER_MS(10)) tss_scan_seq_i (.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i), .ce_i(1'b1), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .afe_ticks_i(ticks), .afe_o(afe),
		.gpi_i(general_input_function), .gpio_o(gpo), .power_mode_o(pmode), .host_irq_n_o(irq_n));
	tss_afe_model tss_afe_model_i (.clk_i(sys_clk_i), .afe_i(afe), .tk_i(tk), .ticks_o(ticks));

	initial begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end

	task automatic final_report();
		$display("checks=%0d mismatches=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// hang guard, far above the roughly 15000 cycles the run needs
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			final_report();
		end
	end

	function automatic logic [3:0] nxt(input logic [3:0] p);
		int j;
		j = p;
		for (int k = 0; k < 12; k++) begin
			j = (j + 1) % 12;
			if (en[j]) return 4'(j);
		end
		return p;
	endfunction

	// each store must land on the next enabled input, wrapping to the lowest
	always @(posedge sys_clk_i) begin
		if (afe.store === 1'b1) begin
			`CHK(afe.sel, nxt(last))
			last = afe.sel;
			stores++;
		end
	end

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk_i);
		penable <= 1'b1;
		do @(posedge sys_clk_i); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// wait for the last input's store plus processing, then step the reference model
	task automatic scan();
		@(posedge sys_clk_i iff (afe.store === 1'b1 && afe.sel === 4'hB));
		repeat (60) @(posedge sys_clk_i);
		for (int i = 0; i < 12; i++) begin
			if (en[i] && tk[i] >= THR_RST + 16'(HYST_RST)) exp_on[i] = 1'b1;
			else if (en[i] && tk[i] < THR_RST - 16'(HYST_RST)) exp_on[i] = 1'b0;
		end
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(19));
		repeat (12) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		apb(1'b0, REG_MODE, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b0, REG_ENABLE, 32'h0);
		`CHK(rd, {20'h0, EN_RST})
		apb(1'b0, REG_THRESH, 32'h0);
		`CHK(rd, {STEP_RST, HYST_RST, THR_RST})
		apb(1'b0, 8'h30, 32'h0);
		`CHK({er, rd}, {1'b1, 32'h0})
		en = 12'($urandom) | 12'h800;
		apb(1'b1, REG_ENABLE, {20'h0, en});
		apb(1'b1, REG_WHEEL_CFG, 32'h0);
		apb(1'b1, REG_ACT_PER, 32'h3C);
		apb(1'b1, REG_DOZE_PER, 32'h14);
		apb(1'b1, REG_GPIO, 32'h5A);
		general_input_function <= 8'($urandom);
		$display("test setup done");
		repeat (2) scan();
		apb(1'b0, REG_GPIO, 32'h0);
		`CHK(rd[15:0], {general_input_function, 8'h5A})
		`CHK(gpo, 8'h5A)
		apb(1'b0, REG_STATUS, 32'h0);
		// random tick levels around both hysteresis edges
		for (int r = 0; r < 6; r++) begin
			for (int i = 0; i < 12; i++) tk[i] = lv[$urandom_range(5)];
			old_on = exp_on;
			scan();
			`CHK(irq_n, 1'(old_on === exp_on))
			apb(1'b0, REG_STATUS, 32'h0);
			`CHK(rd[11:0], exp_on)
			@(negedge sys_clk_i);
			`CHK(irq_n, 1'b1)
		end
		$display("test touch levels done");
		tk = '0;
		scan();
		apb(1'b1, REG_IDLE_LIM, 32'h2);
		// automatic mode moves happen only in processing, so wait for the next period
		scan();
		`CHK(pmode, 2'(MODE_DOZE))
		apb(1'b1, REG_IDLE_LIM, 32'h0);
		tk[11] = 16'h012C;
		scan();
		`CHK(pmode, 2'(MODE_ACTIVE))
		// untouched, so only the disabled timer keeps it active
		tk = '0;
		repeat (2500) @(posedge sys_clk_i);
		`CHK(pmode, 2'(MODE_ACTIVE))
		apb(1'b1, REG_MODE, 32'h1);
		apb(1'b1, REG_WAKE, 32'hBB1);
		scan();
		`CHK(pmode, 2'(MODE_DOZE))
		// touch, release, touch, release of input 11; only the last step wakes
		for (int s = 0; s < 4; s++) begin
			tk[11] = s[0] ? 16'h0000 : 16'h012C;
			scan();
			`CHK(pmode, 2'(s == 3 ? MODE_ACTIVE : MODE_DOZE))
		end
		$display("test wake sequence done");
		// two sensor wheel on inputs 10 and 11, centre of gravity reference
		en = 12'hFFF;
		apb(1'b1, REG_ENABLE, 32'hFFF);
		apb(1'b1, REG_WHEEL_CFG, 32'h00FF0C00);
		scan();
		for (int s = 0; s < 4; s++) begin
			tk[10] = (s != 2) ? 16'h012C : 16'h0000;
			tk[11] = (s == 1 || s == 2) ? 16'h012C : 16'h0000;
			scan();
			pos = (int'(tk[11]) * 255) / (int'(tk[10]) + int'(tk[11]));
			apb(1'b0, REG_WHEEL_POS, 32'h0);
			`CHK(rd[7:0], 8'(pos))
			apb(1'b0, REG_STATUS, 32'h0);
			`CHK(rd[14:12], {s > 0 && prv >= pos + 4, s > 0 && pos >= prv + 4, 1'b1})
			prv = pos;
		end
		$display("test wheel done");
		apb(1'b1, REG_MODE, 32'h2);
		repeat (2) @(negedge sys_clk_i);
		`CHK(pmode, 2'(MODE_SLEEP))
		stores = 0;
		repeat (1500) @(posedge sys_clk_i);
		`CHK(stores, 0)
		apb(1'b1, REG_MODE, 32'h1);
		repeat (2) @(negedge sys_clk_i);
		`CHK(pmode, 2'(MODE_DOZE))
		$display("test modes done");
		final_report();
	end
endmodule
